// ---- design/reduced_power_regs.svh ----
`ifndef REDUCED_POWER_REGS_SVH
`define REDUCED_POWER_REGS_SVH

// APB byte addresses
`define PWR_CTRL_ADDR      12'h000
`define PWR_STATUS_ADDR    12'h004
`define IRQ_LEVEL_A_ADDR   12'h0b8
`define IRQ_LEVEL_B_ADDR   12'h0f8

// Power control field positions
`define IDLE_SELECT_POS    0
`define PDOWN_SELECT_POS   1
`define USER_FLAG_A_POS    2
`define USER_FLAG_B_POS    3

// Level group A: bit 7 is reserved
`define LEVEL_A_RSVD_POS   7

// Wake source indices
`define SRC_EXT0           0
`define SRC_TIMER0         1
`define SRC_EXT1           2
`define SRC_SECONDS        3
`define SRC_TIMER1         4
`define SRC_UART           5
`define SRC_I2C            6
`define SRC_COUNT          7

// Reset values
`define PWR_CTRL_RESET     8'h00
`define IRQ_LEVEL_RESET    8'h00

// Timing; the oscillator period equals one clk period
`define CLK_PERIOD_NS      50
`define OSC_PER_MACHINE    12
`define HF_RESET_OSC       24
`define PLL_RESET_MIN_NS   1000
`define PLL_RESTART_US     63000
`define WDT_RESTART_MACH   3
`define HF_RESET_CYCLES    (`HF_RESET_OSC)
`define PLL_RESET_CYCLES   ((`PLL_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDT_RESTART_CYCLES (`WDT_RESTART_MACH * `OSC_PER_MACHINE)
`define PLL_RESTART_CYCLES (`PLL_RESTART_US * 1000 / `CLK_PERIOD_NS)

`endif

// ---- design/reduced_power_pkg.sv ----
package reduced_power_pkg;

   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_IDLE,
      MODE_PDOWN,
      MODE_RESTART
   } power_mode_e;

   // Pin overrides applied by the power modes
   typedef struct packed {
      logic       addrLatchStrobe;
      logic       programStrobe;
      logic       pulseOutputA;
      logic       pulseOutputB;
      logic       port0Float;
      logic [7:0] port2Out;
      logic       port2DriveN;
      logic       sclDriveN;
      logic       sdaDriveN;
   } pin_ctrl_s;

   typedef struct packed {
      power_mode_e mode;
      logic        userFlagA;
      logic        userFlagB;
      logic [6:0]  levelA;
      logic [7:0]  levelB;
      logic [20:0] restartCnt;
      logic [4:0]  resetHeld;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        cpuHalt;
      logic        cpuResetHold;
      logic        periphRun;
      logic        sysClkRun;
      logic        timer2Reset;
      logic        adcAbort;
      logic        hfOscRun;
      logic        slowOscRun;
      pin_ctrl_s   pins;
   } state_s;

endpackage

// ---- design/reduced_power_mode_control.sv ----
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`include "reduced_power_regs.svh"

module reduced_power_mode_control
   import reduced_power_pkg::*;
#(
   parameter int unsigned PLL_RESTART_CYCLES = `PLL_RESTART_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Interrupt system
   input  wire logic [6:0]  irqPending,
   input  wire logic [6:0]  irqEnable,
   input  wire logic        inServiceHigh,
   input  wire logic        inServiceLow,
   input  wire logic        ext0LevelSense,
   input  wire logic        ext1LevelSense,
   // Resets and oscillator straps
   input  wire logic        hwResetReq,
   input  wire logic        watchdogOverflow,
   input  wire logic        watchdogEnabled,
   input  wire logic        watchdogDisableInput,
   input  wire logic        hfOscSelectInput,
   input  wire logic        keepSlowOscBit,
   // Pin sources from the normal logic
   input  wire logic        extProgMem,
   input  wire logic        addrLatchIn,
   input  wire logic        programStrobeIn,
   input  wire logic        pulseInA,
   input  wire logic        pulseInB,
   input  wire logic [7:0]  port2Latch,
   input  wire logic        i2cPortEnableBit,
   input  wire logic        sclDriveInN,
   input  wire logic        sdaDriveInN,
   // Mode controls
   output logic             cpuHalt,
   output logic             cpuResetHold,
   output logic             periphRun,
   output logic             sysClkRun,
   output logic             timer2Reset,
   output logic             adcAbort,
   output logic             hfOscRun,
   output logic             slowOscRun,
   output pin_ctrl_s        pins
);

   state_s st;
   state_s next_st;

   logic [6:0] srcLevel;
   logic [6:0] armed;
   logic [6:0] blocked;
   logic       idleWake;
   logic       pdCandidate;
   logic       pdWake;
   logic       wrAccess;
   logic       pdAllowed;
   logic [4:0] resetNeeded;
   logic       resetAccepted;

   // Each wake source looks up its own level bit; ext1 and seconds share one
   assign srcLevel[`SRC_EXT0]    = st.levelA[0];
   assign srcLevel[`SRC_TIMER0]  = st.levelA[1];
   assign srcLevel[`SRC_EXT1]    = st.levelA[2];
   assign srcLevel[`SRC_SECONDS] = st.levelA[2];
   assign srcLevel[`SRC_TIMER1]  = st.levelA[3];
   assign srcLevel[`SRC_UART]    = st.levelA[4];
   assign srcLevel[`SRC_I2C]     = st.levelA[5];

   // A source is blocked by an equal or higher level already in service
   assign armed   = irqPending & irqEnable;
   assign blocked = {7{inServiceHigh}} | (~srcLevel & {7{inServiceLow}});
   assign idleWake = |(armed & ~blocked);

   // Only level inputs, and seconds while ext1 is level-sensitive, can restart a stopped clock
   logic [6:0] pdSources;
   assign pdSources = {4'h0,
                       armed[`SRC_SECONDS] & ext1LevelSense,
                       armed[`SRC_EXT1] & ext1LevelSense,
                       armed[`SRC_EXT0] & ext0LevelSense};
   logic [6:0] pdSrcMapped;
   assign pdSrcMapped = {3'h0, pdSources[2], pdSources[1], 1'b0, pdSources[0]};
   assign pdCandidate = |pdSrcMapped;
   assign pdWake      = |(pdSrcMapped & ~blocked);

   // Writes land on the access edge, when pready is already high
   assign wrAccess  = psel & penable & pwrite & st.pready;
   assign pdAllowed = watchdogDisableInput & ~watchdogEnabled;

   // Short reset glitches are ignored; the minimum depends on the oscillator
   assign resetNeeded   = hfOscSelectInput ? 5'(`HF_RESET_CYCLES) : 5'(`PLL_RESET_CYCLES);
   assign resetAccepted = hwResetReq & (st.resetHeld >= resetNeeded - 5'h01);

   // Next state: bus, mode sequencing and registered pin controls
   always_comb begin
      next_st = st;
      next_st.pready  = psel & ~penable;
      next_st.pslverr = 1'b0;
      next_st.prdata  = 32'h0;

      // Setup cycle: decode and latch the answer for the access cycle
      if (psel & ~penable) begin
         unique case (paddr)
            `PWR_CTRL_ADDR: begin
               next_st.prdata[`IDLE_SELECT_POS]  = (st.mode == MODE_IDLE);
               next_st.prdata[`PDOWN_SELECT_POS] = (st.mode == MODE_PDOWN);
               next_st.prdata[`USER_FLAG_A_POS]  = st.userFlagA;
               next_st.prdata[`USER_FLAG_B_POS]  = st.userFlagB;
            end
            `PWR_STATUS_ADDR: begin
               next_st.prdata[1:0] = st.mode;
               next_st.prdata[2]   = st.cpuHalt;
               next_st.prdata[3]   = st.sysClkRun;
            end
            `IRQ_LEVEL_A_ADDR: begin
               next_st.prdata[6:0] = st.levelA;
            end
            `IRQ_LEVEL_B_ADDR: begin
               next_st.prdata[7:0] = st.levelB;
            end
            default: begin
               next_st.pslverr = 1'b1;
            end
         endcase
      end

      // Register writes
      if (wrAccess) begin
         unique case (paddr)
            `PWR_CTRL_ADDR: begin
               next_st.userFlagA = pwdata[`USER_FLAG_A_POS];
               next_st.userFlagB = pwdata[`USER_FLAG_B_POS];
               if (st.mode == MODE_RUN) begin
                  // Power-down wins over idle when both are written and pdAllowed is high
                  if (pwdata[`PDOWN_SELECT_POS] && pdAllowed) begin
                     next_st.mode = MODE_PDOWN;
                  end else if (pwdata[`IDLE_SELECT_POS]) begin
                     next_st.mode = MODE_IDLE;
                  end
               end
            end
            `IRQ_LEVEL_A_ADDR: begin
               next_st.levelA = pwdata[6:0];
            end
            `IRQ_LEVEL_B_ADDR: begin
               next_st.levelB = pwdata[7:0];
            end
            default: begin
            end
         endcase
      end

      // Hardware wake and reset sequencing
      unique case (st.mode)
         MODE_RUN: begin
         end
         MODE_IDLE: begin
            if (idleWake) begin
               next_st.mode = MODE_RUN;
            end
         end
         MODE_PDOWN: begin
            if (pdWake) begin
               next_st.mode = MODE_RUN;
            end else if (pdCandidate) begin
               next_st.mode = MODE_IDLE;
            end
         end
         MODE_RESTART: begin
            if (!hwResetReq) begin
               if (st.restartCnt <= 21'h1) begin
                  next_st.mode = MODE_RUN;
                  next_st.restartCnt = 21'h0;
               end else begin
                  next_st.restartCnt = st.restartCnt - 21'h1;
               end
            end
         end
      endcase

      // Watchdog overflow restarts after a fixed number of machine cycles
      if (watchdogOverflow) begin
         next_st.mode       = MODE_RESTART;
         next_st.restartCnt = 21'(`WDT_RESTART_CYCLES);
      end

      // External reset: counted while held, then registers clear
      next_st.resetHeld = hwResetReq ? ((st.resetHeld == 5'h1f) ? st.resetHeld : st.resetHeld + 5'h01) : 5'h00;
      if (resetAccepted) begin
         next_st.mode       = MODE_RESTART;
         next_st.restartCnt = hfOscSelectInput ? 21'h1 : 21'(PLL_RESTART_CYCLES);
      end
      if (resetAccepted || watchdogOverflow) begin
         next_st.userFlagA = 1'b0;
         next_st.userFlagB = 1'b0;
         next_st.levelA    = 7'h0;
         next_st.levelB    = `IRQ_LEVEL_RESET;
      end

      // Mode outputs follow the next mode so they change together with it
      next_st.cpuHalt      = (next_st.mode != MODE_RUN);
      next_st.cpuResetHold = (next_st.mode == MODE_RESTART);
      next_st.periphRun    = (next_st.mode != MODE_PDOWN);
      next_st.sysClkRun    = (next_st.mode != MODE_PDOWN);
      next_st.timer2Reset  = (next_st.mode == MODE_IDLE) || (next_st.mode == MODE_PDOWN);
      next_st.adcAbort     = next_st.timer2Reset;
      next_st.hfOscRun     = hfOscSelectInput & (next_st.mode != MODE_PDOWN);
      next_st.slowOscRun   = ~hfOscSelectInput & ((next_st.mode != MODE_PDOWN) | keepSlowOscBit);

      // Pins: normal sources pass through, reduced modes override
      next_st.pins.addrLatchStrobe = addrLatchIn;
      next_st.pins.programStrobe   = programStrobeIn;
      next_st.pins.pulseOutputA    = pulseInA;
      next_st.pins.pulseOutputB    = pulseInB;
      next_st.pins.port0Float      = 1'b0;
      next_st.pins.port2Out        = port2Latch;
      next_st.pins.port2DriveN     = 1'b1;
      next_st.pins.sclDriveN       = sclDriveInN;
      next_st.pins.sdaDriveN       = sdaDriveInN;
      if (next_st.mode == MODE_IDLE) begin
         next_st.pins.addrLatchStrobe = 1'b1;
         next_st.pins.programStrobe   = 1'b1;
         next_st.pins.pulseOutputA    = 1'b1;
         next_st.pins.pulseOutputB    = 1'b1;
         next_st.pins.port0Float      = extProgMem;
         if (!i2cPortEnableBit) begin
            next_st.pins.sclDriveN = 1'b1;
            next_st.pins.sdaDriveN = 1'b1;
         end
      end else if (next_st.mode == MODE_PDOWN) begin
         next_st.pins.addrLatchStrobe = 1'b0;
         next_st.pins.programStrobe   = 1'b0;
         next_st.pins.pulseOutputA    = 1'b1;
         next_st.pins.pulseOutputB    = 1'b1;
         next_st.pins.port0Float      = extProgMem;
         next_st.pins.port2DriveN     = ~extProgMem;
         next_st.pins.sclDriveN       = 1'b1;
         next_st.pins.sdaDriveN       = 1'b1;
      end
   end

   // Single state register; reset leaves both modes inactive
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st                      <= '0;
         st.mode                 <= MODE_RUN;
         st.periphRun            <= 1'b1;
         st.sysClkRun            <= 1'b1;
         st.hfOscRun             <= 1'b1;
         st.slowOscRun           <= 1'b0;
         st.pins.addrLatchStrobe <= 1'b1;
         st.pins.programStrobe   <= 1'b1;
         st.pins.pulseOutputA    <= 1'b1;
         st.pins.pulseOutputB    <= 1'b1;
         st.pins.port2DriveN     <= 1'b1;
         st.pins.sclDriveN       <= 1'b1;
         st.pins.sdaDriveN       <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign pready       = st.pready;
   assign prdata       = st.prdata;
   assign pslverr      = st.pslverr;
   assign cpuHalt      = st.cpuHalt;
   assign cpuResetHold = st.cpuResetHold;
   assign periphRun    = st.periphRun;
   assign sysClkRun    = st.sysClkRun;
   assign timer2Reset  = st.timer2Reset;
   assign adcAbort     = st.adcAbort;
   assign hfOscRun     = st.hfOscRun;
   assign slowOscRun   = st.slowOscRun;
   assign pins         = st.pins;

   // Checks on the mode sequencing
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   logic pdWrite;
   logic idleWrite;
   assign pdWrite   = wrAccess && paddr == `PWR_CTRL_ADDR && pwdata[`PDOWN_SELECT_POS] && st.mode == MODE_RUN;
   assign idleWrite = wrAccess && paddr == `PWR_CTRL_ADDR && pwdata[`IDLE_SELECT_POS]
                      && !pwdata[`PDOWN_SELECT_POS] && st.mode == MODE_RUN;

   a_pd_refused_wdt: assert property (
      (pdWrite && watchdogEnabled) |=> st.mode != MODE_PDOWN)
      else $error("power-down entered with watchdog enabled");
   a_pd_needs_input: assert property (
      (pdWrite && !watchdogDisableInput) |=> st.mode != MODE_PDOWN)
      else $error("power-down entered with disable input low");
   a_idle_entry_halt: assert property (
      (idleWrite && !watchdogOverflow && !resetAccepted) |=> (st.mode == MODE_IDLE && cpuHalt))
      else $error("idle write did not halt the cpu");
   a_idle_pin_levels: assert property (
      st.mode == MODE_IDLE |-> (pins.addrLatchStrobe && pins.programStrobe && pins.pulseOutputA && pins.pulseOutputB))
      else $error("idle pin levels wrong");
   a_pd_pin_levels: assert property (
      st.mode == MODE_PDOWN |-> (!pins.addrLatchStrobe && !pins.programStrobe && pins.pulseOutputB && !sysClkRun))
      else $error("power-down pin levels wrong");
   a_i2c_pd_float: assert property (
      st.mode == MODE_PDOWN |-> (pins.sclDriveN && pins.sdaDriveN))
      else $error("i2c pins driven in power-down");
   a_idle_wake_exit: assert property (
      (st.mode == MODE_IDLE && idleWake && !watchdogOverflow && !resetAccepted) |=> (st.mode == MODE_RUN && !cpuHalt))
      else $error("unblocked interrupt did not end idle");
   a_pd_blocked_idle: assert property (
      (st.mode == MODE_PDOWN && pdCandidate && !pdWake && !watchdogOverflow && !resetAccepted)
      |=> st.mode == MODE_IDLE)
      else $error("blocked wake did not move to idle");
   a_wdt_restart_len: assert property (
      (watchdogOverflow && !hwResetReq && st.resetHeld == 5'h0) ##1 (!watchdogOverflow && !hwResetReq) [*8]
      |-> ##28 cpuResetHold ##1 !cpuResetHold)
      else $error("watchdog restart length wrong");
   a_level_rsvd_zero: assert property (
      (psel && !penable && paddr == `IRQ_LEVEL_A_ADDR) |=> prdata[31:7] == 25'h0)
      else $error("reserved level bit reads non-zero");

   // Clock, oscillator, port and unit states held by the reduced modes; inputs seen one edge back
   a_pd_osc_state: assert property (
      st.mode == MODE_PDOWN |-> (!hfOscRun && slowOscRun == (!$past(hfOscSelectInput) && $past(keepSlowOscBit))))
      else $error("oscillator state wrong in power-down");
   a_pd_port2_drive: assert property (
      st.mode == MODE_PDOWN |-> (pins.port2DriveN == !$past(extProgMem) && pins.port2Out == $past(port2Latch)))
      else $error("port 2 not driven from its latch in power-down");
   a_idle_i2c_float: assert property (
      (st.mode == MODE_IDLE && !$past(i2cPortEnableBit)) |-> (pins.sclDriveN && pins.sdaDriveN))
      else $error("i2c pins driven in idle with the port disabled");
   a_idle_units_state: assert property (
      st.mode == MODE_IDLE |-> (timer2Reset && adcAbort && periphRun && sysClkRun))
      else $error("idle unit controls wrong");

   c_idle_entered:  cover property (st.mode == MODE_RUN ##1 st.mode == MODE_IDLE);
   c_pd_entered:    cover property (st.mode == MODE_RUN ##1 st.mode == MODE_PDOWN);
   c_pd_to_idle:    cover property (st.mode == MODE_PDOWN ##1 st.mode == MODE_IDLE);
   c_restart_done:  cover property (st.mode == MODE_RESTART ##1 st.mode == MODE_RUN);
   c_wdt_restart:   cover property (watchdogOverflow ##1 cpuResetHold);

endmodule // reduced_power_mode_control

// ---- testbench/irq_partner.sv ----
`timescale 1ns/1ns

// Interrupt side of the core: requests are held until the core runs again
module irq_partner (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       cpuHalt,
   input  wire logic [6:0] raise,
   output logic [6:0]      irqPending,
   output logic            inServiceLow
);
   logic [2:0] svcCnt;

   // Wake lines stay asserted until cpuHalt falls, so a slow restart never loses them
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irqPending <= 7'h00;
         svcCnt     <= 3'h0;
      end else if (!cpuHalt && irqPending != 7'h00) begin
         irqPending <= raise;
         svcCnt     <= 3'h4;
      end else begin
         irqPending <= irqPending | raise;
         svcCnt     <= (svcCnt != 3'h0) ? svcCnt - 3'h1 : 3'h0;
      end
   end

   // A low-level routine runs a few cycles, then returns
   assign inServiceLow = (svcCnt != 3'h0);
endmodule // irq_partner

// ---- testbench/tb_reduced_power_mode_control.sv ----
`timescale 1ns/1ns
`include "reduced_power_regs.svh"

module tb_reduced_power_mode_control
   import reduced_power_pkg::*;
;
   logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, spin = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, v;
   logic [6:0]  irqEnable = 7'h7f, raise = 7'h00, irqPending;
   logic        inServiceHigh = 1'b0, hwResetReq = 1'b0, wdOvf = 1'b0, wdEn = 1'b0, wdDis = 1'b1, hfSel = 1'b1;
   logic        ext1Lvl = 1'b1;
   logic        pready, pslverr, inServiceLow, cpuHalt, cpuResetHold, periphRun, sysClkRun;
   logic        timer2Reset, adcAbort, hfOscRun, slowOscRun;
   logic [13:0] noise = 14'h0;
   logic [33:0] e;
   logic [33:0] q[$];
   pin_ctrl_s   pins;
   int          bad_count = 0, cmp_count = 0, k;
   integer      seed = 32'hbd2b;

   always #25 clk = ~clk;

   // Pass-through pins wander so the mode overrides are seen doing work
   always @(posedge clk) if (spin) noise <= 14'($random(seed));

   reduced_power_mode_control #(.PLL_RESTART_CYCLES(50)) reduced_power_mode_control_inst (
      .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irqPending(irqPending),
      .irqEnable(irqEnable), .inServiceHigh(inServiceHigh), .inServiceLow(inServiceLow),
      .ext0LevelSense(1'b1), .ext1LevelSense(ext1Lvl), .hwResetReq(hwResetReq), .watchdogOverflow(wdOvf),
      .watchdogEnabled(wdEn), .watchdogDisableInput(wdDis), .hfOscSelectInput(hfSel),
      .keepSlowOscBit(1'b1), .extProgMem(1'b1), .addrLatchIn(noise[0]), .programStrobeIn(noise[1]),
      .pulseInA(noise[2]), .pulseInB(noise[3]), .port2Latch(noise[13:6]), .i2cPortEnableBit(1'b0),
      .sclDriveInN(noise[4]), .sdaDriveInN(noise[5]), .cpuHalt(cpuHalt), .cpuResetHold(cpuResetHold),
      .periphRun(periphRun), .sysClkRun(sysClkRun), .timer2Reset(timer2Reset), .adcAbort(adcAbort),
      .hfOscRun(hfOscRun), .slowOscRun(slowOscRun), .pins(pins));

   irq_partner irq_partner_inst (.clk(clk), .resetn(resetn), .cpuHalt(cpuHalt), .raise(raise),
      .irqPending(irqPending), .inServiceLow(inServiceLow));

   task close_out;
      if (bad_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task chk(input logic [32:0] got, input logic [32:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task step(input int c);
      repeat (c) @(posedge clk);
   endtask

   // One APB transfer; the expected answer is noted for the monitor
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err, input logic [31:0] x);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      q.push_back({wr, err, x});
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         close_out();
      end else begin
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task waitHalt(input logic lv);
      int n;
      n = 0;
      while (cpuHalt !== lv && n < 8) begin
         @(posedge clk);
         n++;
      end
      chk({32'h0, cpuHalt}, {32'h0, lv});
   endtask

   // Monitor: each completed transfer takes the oldest note
   always @(posedge clk) if (psel && penable && pready === 1'b1) begin
      e = q.pop_front();
      if (e[33]) chk({pslverr, 32'h0}, {e[32], 32'h0});
      else chk({pslverr, prdata}, e[32:0]);
   end

   // Hang guard
   initial begin
      step(20000);
      bad_count++;
      close_out();
   end

   initial begin
      step(3);
      resetn <= 1'b1;
      apb(0, `PWR_CTRL_ADDR, 32'h0, 0, 32'h0);
      apb(0, `IRQ_LEVEL_A_ADDR, 32'h0, 0, 32'h0);
      apb(0, `IRQ_LEVEL_B_ADDR, 32'h0, 0, 32'h0);
      apb(1, `IRQ_LEVEL_A_ADDR, 32'hff, 0, 32'h0);
      apb(0, `IRQ_LEVEL_A_ADDR, 32'h0, 0, 32'h7f);
      v = $random(seed);
      apb(1, `IRQ_LEVEL_B_ADDR, {24'h0, v[7:0]}, 0, 32'h0);
      apb(0, `IRQ_LEVEL_B_ADDR, 32'h0, 0, {24'h0, v[7:0]});
      apb(1, 12'h010, 32'h1, 1, 32'h0);
      apb(1, `PWR_CTRL_ADDR, 32'hc, 0, 32'h0);
      apb(0, `PWR_CTRL_ADDR, 32'h0, 0, 32'hc);
      // Power-down refused while the watchdog may run
      wdEn <= 1'b1;
      apb(1, `PWR_CTRL_ADDR, 32'h2, 0, 32'h0);
      apb(0, `PWR_STATUS_ADDR, 32'h0, 0, 32'h8);
      wdEn <= 1'b0;
      wdDis <= 1'b0;
      apb(1, `PWR_CTRL_ADDR, 32'h2, 0, 32'h0);
      apb(0, `PWR_STATUS_ADDR, 32'h0, 0, 32'h8);
      wdDis <= 1'b1;
      // Idle: blocked wake first, then released
      apb(1, `PWR_CTRL_ADDR, 32'h1, 0, 32'h0);
      #1 chk({cpuHalt, timer2Reset, adcAbort, periphRun, pins[15:12], pins[1:0]}, 33'h3ff);
      apb(0, `PWR_STATUS_ADDR, 32'h0, 0, 32'hd);
      inServiceHigh <= 1'b1;
      raise <= 7'h01;
      step(1);
      raise <= 7'h00;
      step(5);
      #1 chk({32'h0, cpuHalt}, 33'h1);
      step(1);
      inServiceHigh <= 1'b0;
      waitHalt(1'b0);
      // Watchdog restart out of idle
      apb(1, `PWR_CTRL_ADDR, 32'h1, 0, 32'h0);
      wdOvf <= 1'b1;
      step(1);
      wdOvf <= 1'b0;
      k = 0;
      repeat (60) begin
         @(posedge clk);
         if (cpuResetHold === 1'b1) k++;
      end
      chk(33'(k), 33'd36);
      // Power-down on the slow oscillator, never from inside a routine
      step(8);
      hfSel <= 1'b0;
      spin <= 1'b0;
      apb(1, `PWR_CTRL_ADDR, 32'h2, 0, 32'h0);
      #1 chk({28'h0, sysClkRun, periphRun, cpuHalt, hfOscRun, slowOscRun}, 33'h05);
      chk({17'h0, pins}, {17'h0, 4'h3, 1'b1, noise[13:6], 3'h3});
      raise <= 7'h02;
      step(1);
      raise <= 7'h00;
      step(5);
      #1 chk({32'h0, sysClkRun}, 33'h0);
      step(1);
      inServiceHigh <= 1'b1;
      raise <= 7'h04;
      step(1);
      raise <= 7'h00;
      step(3);
      #1 chk({31'h0, cpuHalt, sysClkRun}, 33'h3);
      step(1);
      inServiceHigh <= 1'b0;
      waitHalt(1'b0);
      spin <= 1'b1;
      // Seconds and ext0 wakes, unblocked
      for (int s = 3; s >= 0; s -= 3) begin
         step(8);
         // Seconds first tried with ext1 edge-triggered: it must not wake until ext1 is level-sensitive
         ext1Lvl <= (s == 0);
         apb(1, `PWR_CTRL_ADDR, 32'h2, 0, 32'h0);
         raise <= 7'h01 << s;
         step(1);
         raise <= 7'h00;
         step(4);
         #1 chk({32'h0, sysClkRun}, {32'h0, s == 0});
         step(1);
         ext1Lvl <= 1'b1;
         waitHalt(1'b0);
         apb(0, `PWR_STATUS_ADDR, 32'h0, 0, 32'h8);
      end
      // External reset: too short is ignored, long enough restarts
      hfSel <= 1'b1;
      apb(1, `IRQ_LEVEL_A_ADDR, 32'h55, 0, 32'h0);
      hwResetReq <= 1'b1;
      step(22);
      hwResetReq <= 1'b0;
      apb(0, `IRQ_LEVEL_A_ADDR, 32'h0, 0, 32'h55);
      hwResetReq <= 1'b1;
      step(30);
      #1 chk({32'h0, cpuResetHold}, 33'h1);
      step(1);
      hwResetReq <= 1'b0;
      step(3);
      apb(0, `IRQ_LEVEL_A_ADDR, 32'h0, 0, 32'h0);
      step(2);
      close_out();
   end
endmodule // tb_reduced_power_mode_control
